/* File: core/pfcd_cfg.svh */
// Purpose: constants for the parallel flash command host
// Assumes: word-wide unlock locations unless byte mode is selected
// Notes: all offsets, codes and timing counts live here
`ifndef PFCD_CFG_SVH
`define PFCD_CFG_SVH
`define PFCD_UNLOCK1_WORD 11'h555
`define PFCD_UNLOCK2_WORD 11'h2aa
`define PFCD_UNLOCK1_BYTE 12'haaa
`define PFCD_UNLOCK2_BYTE 12'h555
`define PFCD_DATA_UNLOCK1 8'haa
`define PFCD_DATA_UNLOCK2 8'h55
`define PFCD_CMD_RESET 8'hf0
`define PFCD_CMD_IDENT 8'h90
`define PFCD_CMD_PROGRAM 8'ha0
`define PFCD_CMD_ERASE_SETUP 8'h80
`define PFCD_CMD_CHIP_ERASE 8'h10
`define PFCD_CMD_SECTOR_ERASE 8'h30
`define PFCD_CYCLE_NS 25
`define PFCD_SETUP_NS 50
`define PFCD_STROBE_NS 75
`define PFCD_ACCESS_NS 100
`define PFCD_SETUP_CYC (((`PFCD_SETUP_NS) + (`PFCD_CYCLE_NS) - 1) / (`PFCD_CYCLE_NS))
`define PFCD_STROBE_CYC (((`PFCD_STROBE_NS) + (`PFCD_CYCLE_NS) - 1) / (`PFCD_CYCLE_NS))
`define PFCD_ACCESS_CYC (((`PFCD_ACCESS_NS) + (`PFCD_CYCLE_NS) - 1) / (`PFCD_CYCLE_NS))
`define PFCD_IDENT_MANUF 2'h0
`define PFCD_IDENT_DEVICE 2'h1
`endif

/* File: core/pfcd_host.sv */
// Purpose: host controller driving a parallel nor flash by its pins
// Assumes: one command at a time, pins sampled through two flops
// Notes: data bus split into input, output and output enable
// Functional notes
// - commands except reset open with two unlock writes
// - single f0 write resets to array read
// - unlock then 90 enters identifier mode
// - program is four writes ending with data
// - chip erase is six writes
// - sector erase sixth write at sector
// - read: select, gate low, strobe high
// - write: strobe, select low, gate high
// - identifier mode until reset command
// - toggle bit stops twice: done
`timescale 1ns/100ps
`default_nettype none
`include "pfcd_cfg.svh"
module pfcd_host #(
   parameter int ADDR_W = 19,
   parameter int POLL_MAX = 65535
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic byte_mode_in,
   input wire logic req_in,
   input wire logic [2:0] op_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [15:0] wdata_in,
   output logic busy_out,
   output logic done_out,
   output logic timeout_out,
   output logic [15:0] rdata_out,
   output logic chip_sel_n_out,
   output logic out_gate_n_out,
   output logic wr_strobe_n_out,
   output logic hw_reset_n_out,
   output logic [ADDR_W-1:0] flash_addr_out,
   output logic [15:0] flash_data_out,
   output logic flash_data_oe_out,
   input wire logic [15:0] flash_data_in
);
   if (ADDR_W < 12 || POLL_MAX < 2 || POLL_MAX > 131071)
   begin : g_bad_params
      $error("pfcd_host: unsupported parameters");
   end
   localparam logic [3:0] SETUP_CYC = 4'(`PFCD_SETUP_CYC);
   localparam logic [3:0] STROBE_CYC = 4'(`PFCD_STROBE_CYC);
   localparam logic [3:0] ACCESS_CYC = 4'(`PFCD_ACCESS_CYC);
   typedef struct packed {
      pfcd_pkg::pfcd_state_t st;
      pfcd_pkg::pfcd_op_t op;
      logic [2:0] step;
      logic [3:0] cnt;
      logic [16:0] poll;
      logic [1:0] stable;
      logic last_tog;
      logic [ADDR_W-1:0] uaddr;
      logic [15:0] udata;
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic busy;
      logic done;
      logic tmo;
      logic [15:0] rdata;
      logic cs_n;
      logic og_n;
      logic we_n;
      logic rst_n;
      logic [ADDR_W-1:0] fa;
      logic [15:0] fd;
      logic oe;
   } pfcd_state_s_t;
   pfcd_state_s_t s_q;
   pfcd_state_s_t s_d;
   logic [ADDR_W-1:0] rom_addr;
   logic [15:0] rom_data;
   logic rom_last;
   function automatic logic pfcd_is_write_op(input pfcd_pkg::pfcd_op_t o);
      pfcd_is_write_op = (o != pfcd_pkg::PFCD_OP_READ);
   endfunction : pfcd_is_write_op
   function automatic logic pfcd_is_algo(input pfcd_pkg::pfcd_op_t o);
      pfcd_is_algo = (o == pfcd_pkg::PFCD_OP_PROGRAM) || (o == pfcd_pkg::PFCD_OP_CHIP_ERASE) ||
         (o == pfcd_pkg::PFCD_OP_SECTOR_ERASE);
   endfunction : pfcd_is_algo
   pfcd_seq_rom #(
      .ADDR_W(ADDR_W)
   ) u_rom (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .byte_mode_in(byte_mode_in),
      .op_in(s_q.op),
      .step_in(s_q.step),
      .user_addr_in(s_q.uaddr),
      .user_data_in(s_q.udata),
      .addr_out(rom_addr),
      .data_out(rom_data),
      .last_out(rom_last)
   );
   always_comb
   begin
      s_d = s_q;
      s_d.sync1 = flash_data_in;
      s_d.sync2 = s_q.sync1;
      s_d.done = 1'b0;
      s_d.rst_n = 1'b1;
      case (s_q.st)
         pfcd_pkg::PFCD_ST_IDLE:
         begin
            s_d.cs_n = 1'b1;
            s_d.og_n = 1'b1;
            s_d.we_n = 1'b1;
            s_d.oe = 1'b0;
            s_d.busy = 1'b0;
            if (req_in && op_in <= 3'h5)
            begin
               s_d.op = pfcd_pkg::pfcd_op_t'(op_in);
               s_d.uaddr = addr_in;
               s_d.udata = wdata_in;
               s_d.step = 3'h0;
               s_d.cnt = 4'h0;
               s_d.busy = 1'b1;
               s_d.tmo = 1'b0;
               s_d.st = (op_in == 3'h0) ? pfcd_pkg::PFCD_ST_READ : pfcd_pkg::PFCD_ST_SETUP;
               s_d.fa = addr_in;
            end
         end
         pfcd_pkg::PFCD_ST_SETUP:
         begin
            s_d.fa = rom_addr;
            s_d.fd = rom_data;
            s_d.oe = 1'b1;
            s_d.og_n = 1'b1;
            s_d.cs_n = 1'b0;
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt + 4'h1 >= SETUP_CYC + 4'h1) // extra cycle covers rom latency
            begin
               s_d.we_n = 1'b0;
               s_d.cnt = 4'h0;
               s_d.st = pfcd_pkg::PFCD_ST_STROBE;
            end
         end
         pfcd_pkg::PFCD_ST_STROBE:
         begin
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt + 4'h1 >= STROBE_CYC)
            begin
               s_d.we_n = 1'b1;
               s_d.cnt = 4'h0;
               s_d.st = pfcd_pkg::PFCD_ST_HOLD;
            end
         end
         pfcd_pkg::PFCD_ST_HOLD:
         begin
            s_d.cs_n = 1'b1;
            s_d.oe = 1'b0;
            s_d.step = s_q.step + 3'h1;
            s_d.st = pfcd_pkg::PFCD_ST_SETUP;
            if (rom_last)
            begin
               s_d.poll = 17'h00000;
               s_d.stable = 2'h0;
               if (pfcd_is_algo(s_q.op))
               begin
                  s_d.fa = s_q.uaddr;
                  s_d.st = pfcd_pkg::PFCD_ST_POLL;
               end
               else
               begin
                  s_d.done = 1'b1;
                  s_d.busy = 1'b0;
                  s_d.st = pfcd_pkg::PFCD_ST_IDLE;
               end
            end
         end
         pfcd_pkg::PFCD_ST_READ:
         begin
            s_d.oe = 1'b0;
            s_d.we_n = 1'b1;
            s_d.cs_n = 1'b0;
            s_d.og_n = 1'b0;
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt + 4'h1 >= ACCESS_CYC + 4'h2)
            begin
               s_d.rdata = s_q.sync2;
               s_d.cs_n = 1'b1;
               s_d.og_n = 1'b1;
               s_d.cnt = 4'h0;
               s_d.done = 1'b1;
               s_d.busy = 1'b0;
               s_d.st = pfcd_pkg::PFCD_ST_IDLE;
            end
         end
         pfcd_pkg::PFCD_ST_POLL:
         begin
            s_d.cs_n = 1'b0;
            s_d.og_n = 1'b0;
            s_d.oe = 1'b0;
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt + 4'h1 >= ACCESS_CYC + 4'h2)
            begin
               s_d.cnt = 4'h0;
               s_d.og_n = 1'b1;
               s_d.last_tog = s_q.sync2[6];
               s_d.poll = s_q.poll + 17'h00001;
               if (s_q.poll != 17'h00000 && s_q.sync2[6] == s_q.last_tog)
               begin
                  s_d.stable = s_q.stable + 2'h1;
               end
               else
               begin
                  s_d.stable = 2'h0;
               end
               if (s_q.poll != 17'h00000 && s_q.sync2[6] == s_q.last_tog && s_q.stable == 2'h1)
               begin
                  s_d.rdata = s_q.sync2;
                  s_d.cs_n = 1'b1;
                  s_d.done = 1'b1;
                  s_d.busy = 1'b0;
                  s_d.st = pfcd_pkg::PFCD_ST_IDLE;
               end
               else if (s_q.poll >= 17'(POLL_MAX))
               begin
                  s_d.tmo = 1'b1;
                  s_d.done = 1'b1;
                  s_d.busy = 1'b0;
                  s_d.cs_n = 1'b1;
                  s_d.st = pfcd_pkg::PFCD_ST_IDLE;
               end
            end
         end
         default:
         begin
            s_d.st = pfcd_pkg::PFCD_ST_IDLE;
         end
      endcase
      if (!pfcd_is_write_op(s_q.op) && s_q.st == pfcd_pkg::PFCD_ST_SETUP)
      begin
         s_d.st = pfcd_pkg::PFCD_ST_IDLE;
      end
   end
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         s_q <= '0;
         s_q.st <= pfcd_pkg::PFCD_ST_IDLE;
         s_q.op <= pfcd_pkg::PFCD_OP_READ;
         s_q.cs_n <= 1'b1;
         s_q.og_n <= 1'b1;
         s_q.we_n <= 1'b1;
         s_q.rst_n <= 1'b0;
      end
      else if (clk_en_in)
      begin
         s_q <= s_d;
      end
   end
   assign busy_out = s_q.busy;
   assign done_out = s_q.done;
   assign timeout_out = s_q.tmo;
   assign rdata_out = s_q.rdata;
   assign chip_sel_n_out = s_q.cs_n;
   assign out_gate_n_out = s_q.og_n;
   assign wr_strobe_n_out = s_q.we_n;
   assign hw_reset_n_out = s_q.rst_n;
   assign flash_addr_out = s_q.fa;
   assign flash_data_out = s_q.fd;
   assign flash_data_oe_out = s_q.oe;
endmodule : pfcd_host
`default_nettype wire

/* File: core/pfcd_pkg.sv */
// Purpose: types for the parallel flash command host
// Assumes: constants come from pfcd_cfg.svh
// Notes: no constants here
package pfcd_pkg;
   typedef enum logic [2:0]
   {
      PFCD_OP_READ,
      PFCD_OP_RESET,
      PFCD_OP_IDENT,
      PFCD_OP_PROGRAM,
      PFCD_OP_CHIP_ERASE,
      PFCD_OP_SECTOR_ERASE
   } pfcd_op_t;
   typedef enum logic [2:0]
   {
      PFCD_ST_IDLE,
      PFCD_ST_SETUP,
      PFCD_ST_STROBE,
      PFCD_ST_HOLD,
      PFCD_ST_READ,
      PFCD_ST_POLL
   } pfcd_state_t;
endpackage : pfcd_pkg

/* File: core/pfcd_seq_rom.sv */
// Purpose: bus-cycle table of address and data for each command
// Assumes: step index counts the cycles of one command
// Notes: read data come out of a register
`timescale 1ns/100ps
`default_nettype none
`include "pfcd_cfg.svh"
module pfcd_seq_rom #(
   parameter int ADDR_W = 19
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic byte_mode_in,
   input wire pfcd_pkg::pfcd_op_t op_in,
   input wire logic [2:0] step_in,
   input wire logic [ADDR_W-1:0] user_addr_in,
   input wire logic [15:0] user_data_in,
   output logic [ADDR_W-1:0] addr_out,
   output logic [15:0] data_out,
   output logic last_out
);
   if (ADDR_W < 12)
   begin : g_bad_params
      $error("pfcd_seq_rom: unsupported parameters");
   end
   logic [ADDR_W-1:0] a1;
   logic [ADDR_W-1:0] a2;
   logic [ADDR_W-1:0] a_d;
   logic [15:0] d_d;
   logic l_d;
   always_comb
   begin
      a1 = byte_mode_in ? ADDR_W'(`PFCD_UNLOCK1_BYTE) : ADDR_W'(`PFCD_UNLOCK1_WORD);
      a2 = byte_mode_in ? ADDR_W'(`PFCD_UNLOCK2_BYTE) : ADDR_W'(`PFCD_UNLOCK2_WORD);
      a_d = a1;
      d_d = 16'h0000;
      l_d = 1'b0;
      case (step_in)
         3'h0, 3'h3:
         begin
            a_d = a1;
            d_d = {8'h00, `PFCD_DATA_UNLOCK1};
         end
         3'h1, 3'h4:
         begin
            a_d = a2;
            d_d = {8'h00, `PFCD_DATA_UNLOCK2};
         end
         3'h2:
         begin
            a_d = a1;
            case (op_in)
               pfcd_pkg::PFCD_OP_IDENT: d_d = {8'h00, `PFCD_CMD_IDENT};
               pfcd_pkg::PFCD_OP_PROGRAM: d_d = {8'h00, `PFCD_CMD_PROGRAM};
               default: d_d = {8'h00, `PFCD_CMD_ERASE_SETUP};
            endcase
            l_d = (op_in == pfcd_pkg::PFCD_OP_IDENT);
         end
         3'h5:
         begin
            if (op_in == pfcd_pkg::PFCD_OP_SECTOR_ERASE)
            begin
               a_d = user_addr_in;
               d_d = {8'h00, `PFCD_CMD_SECTOR_ERASE};
            end
            else
            begin
               a_d = a1;
               d_d = {8'h00, `PFCD_CMD_CHIP_ERASE};
            end
            l_d = 1'b1;
         end
         default:
         begin
            a_d = user_addr_in;
            d_d = user_data_in;
            l_d = 1'b1;
         end
      endcase
      if (op_in == pfcd_pkg::PFCD_OP_RESET)
      begin
         a_d = user_addr_in;
         d_d = {8'h00, `PFCD_CMD_RESET};
         l_d = 1'b1;
      end
      if (op_in == pfcd_pkg::PFCD_OP_PROGRAM && step_in == 3'h3)
      begin
         a_d = user_addr_in;
         d_d = user_data_in;
         l_d = 1'b1;
      end
   end
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         addr_out <= '0;
         data_out <= 16'h0000;
         last_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         addr_out <= a_d;
         data_out <= d_d;
         last_out <= l_d;
      end
   end
endmodule : pfcd_seq_rom
`default_nettype wire

/* File: testbench/pfcd_flash_model.sv */
// Purpose: behavioural flash command logic
// Assumes: word-wide identifier reads
// Notes: reports last accepted command
`timescale 1ns/100ps
`default_nettype none
module pfcd_flash_model #(
   parameter int ADDR_W = 19,
   parameter logic [15:0] MAN = 16'h0000,
   parameter logic [15:0] DEV = 16'h0000
) (
   input wire logic cs_n_in,
   input wire logic og_n_in,
   input wire logic we_n_in,
   input wire logic rst_n_in,
   input wire logic byte_in,
   input wire logic slow_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic [2:0] kind_out,
   output logic [ADDR_W-1:0] loc_out,
   output logic [15:0] val_out,
   output logic [3:0] nwr_out
);
   logic [ADDR_W-1:0] a_q;
   logic [2:0] st = 3'h0;
   logic id = 1'b0;
   logic [7:0] nrd = 8'h00;
   logic [7:0] rd0 = 8'h00;
   logic [7:0] len = 8'h00;
   logic busy;
   logic [15:0] val;
   logic [15:0] last = 16'h0000;
   logic [11:0] lo;
   logic [11:0] u1;
   logic [11:0] u2;
   assign lo = a_q[11:0] & (byte_in ? 12'hfff : 12'h7ff);
   assign u1 = byte_in ? 12'haaa : 12'h555;
   assign u2 = byte_in ? 12'h555 : 12'h2aa;
   assign busy = (nrd - rd0) < len;
   task start_algo(input logic [2:0] k);
      st = 3'h0;
      kind_out = k;
      rd0 = nrd;
      len = slow_in ? 8'h14 : 8'h03;
   endtask : start_algo
   always @(negedge we_n_in) a_q = addr_in;
   always @(posedge we_n_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st = 3'h0;
         id = 1'b0;
         len = 8'h00;
         kind_out = 3'h0;
         nwr_out = 4'h0;
      end
      else if (!cs_n_in && !busy)
      begin
         nwr_out = nwr_out + 4'h1;
         if (st == 3'h6)
         begin
            loc_out = a_q;
            val_out = data_in;
            start_algo(3'h3);
         end
         else if (data_in == 16'h00f0)
         begin
            st = 3'h0;
            id = 1'b0;
            kind_out = 3'h1;
         end
         else if (st == 3'h5 && data_in == 16'h0030)
         begin
            loc_out = a_q;
            start_algo(3'h5);
         end
         else if (st == 3'h5 && lo == u1 && data_in == 16'h0010)
         begin
            start_algo(3'h4);
         end
         else if (st == 3'h2 && lo == u1 && data_in == 16'h0090)
         begin
            st = 3'h0;
            id = 1'b1;
            kind_out = 3'h2;
         end
         else
         begin
            case (st)
               3'h0: st = (lo == u1 && data_in == 16'h00aa) ? 3'h1 : 3'h0;
               3'h1: st = (lo == u2 && data_in == 16'h0055) ? 3'h2 : 3'h0;
               3'h2: st = lo != u1 ? 3'h0 : data_in == 16'h00a0 ? 3'h6 : data_in == 16'h0080 ? 3'h3 : 3'h0;
               3'h3: st = (lo == u1 && data_in == 16'h00aa) ? 3'h4 : 3'h0;
               3'h4: st = (lo == u2 && data_in == 16'h0055) ? 3'h5 : 3'h0;
               default: st = 3'h0;
            endcase
         end
      end
   end
   assign val = busy ? {9'h000, nrd[0], 6'h00} : id ? (addr_in[1] ? 16'h0000 : addr_in[0] ? DEV : MAN)
      : addr_in[15:0] ^ 16'h5a5a;
   assign data_out = (!cs_n_in && !og_n_in && rst_n_in) ? val : ~last;
   always @(posedge og_n_in)
   begin
      last = val;
      nrd = nrd + 8'h01;
   end
endmodule : pfcd_flash_model
`default_nettype wire

/* File: testbench/pfcd_host_properties.sv */
// Purpose: pin checks of the flash host
// Assumes: one clock, async high reset
// Notes: bound below
`timescale 1ns/100ps
`default_nettype none
module pfcd_host_properties #(
   parameter int ADDR_W = 19
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic timeout_out,
   input wire logic chip_sel_n_out,
   input wire logic out_gate_n_out,
   input wire logic wr_strobe_n_out,
   input wire logic hw_reset_n_out,
   input wire logic [ADDR_W-1:0] flash_addr_out,
   input wire logic [15:0] flash_data_out,
   input wire logic flash_data_oe_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   a_reset_pins: assert property (disable iff (1'b0) sys_rst_in |-> !hw_reset_n_out && chip_sel_n_out)
      else $error("pins not parked in reset");
   a_write_gate: assert property (!wr_strobe_n_out |-> !chip_sel_n_out && out_gate_n_out && flash_data_oe_out)
      else $error("write strobe without select");
   a_read_gate: assert property (!out_gate_n_out |-> !chip_sel_n_out && wr_strobe_n_out && hw_reset_n_out)
      else $error("read gate with bad pins");
   a_strobe_len: assert property ($fell(wr_strobe_n_out) |-> !wr_strobe_n_out[*3] ##1 wr_strobe_n_out)
      else $error("strobe length wrong");
   a_read_len: assert property ($fell(out_gate_n_out) |-> !out_gate_n_out[*4] ##[1:3] out_gate_n_out)
      else $error("read too short");
   a_write_hold: assert property (!wr_strobe_n_out |-> $stable(flash_addr_out) && $stable(flash_data_out))
      else $error("bus moved in strobe");
   a_no_fight: assert property (flash_data_oe_out |-> out_gate_n_out)
      else $error("drive during read");
   a_idle_quiet: assert property (!busy_out && !$past(busy_out) |-> chip_sel_n_out && wr_strobe_n_out)
      else $error("pins active when idle");
   a_done_pulse: assert property (done_out |-> !busy_out ##1 !done_out)
      else $error("done not a pulse");
   a_timeout_done: assert property ($rose(timeout_out) |-> done_out)
      else $error("timeout without done");
   c_write: cover property ($fell(wr_strobe_n_out));
   c_read: cover property ($fell(out_gate_n_out));
   c_timeout: cover property ($rose(timeout_out));
endmodule : pfcd_host_properties
bind pfcd_host pfcd_host_properties #(.ADDR_W(ADDR_W)) u_pfcd_host_properties (
   .clk_in(clk_in),
   .sys_rst_in(sys_rst_in),
   .busy_out(busy_out),
   .done_out(done_out),
   .timeout_out(timeout_out),
   .chip_sel_n_out(chip_sel_n_out),
   .out_gate_n_out(out_gate_n_out),
   .wr_strobe_n_out(wr_strobe_n_out),
   .hw_reset_n_out(hw_reset_n_out),
   .flash_addr_out(flash_addr_out),
   .flash_data_out(flash_data_out),
   .flash_data_oe_out(flash_data_oe_out)
);
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench of the flash host
// Assumes: poll limit cut to 8
// Notes: ident reads in word mode
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam logic [15:0] MAN = 16'h00a7; // arbitrary value
   localparam logic [15:0] DEV = 16'h3c81; // arbitrary value
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b0;
   logic clk_en_in = 1'b1;
   logic byte_mode_in = 1'b0;
   logic req_in = 1'b0;
   logic slow = 1'b0;
   logic [2:0] op_in = 3'h0;
   logic [18:0] addr_in = 19'h00000;
   logic [15:0] wdata_in = 16'h0000;
   wire busy, done, tmo, cs_n, og_n, we_n, rst_n, oe;
   wire [15:0] rdata, fdo, fdi, mdo, mval;
   wire [18:0] fa, mloc;
   wire [2:0] kind;
   wire [3:0] nwr;
   int mismatches = 0;
   int n_checks = 0;
   logic [3:0] n0;
   logic [3:0] dn;
   assign fdi = oe ? fdo : mdo;
   initial forever #12.5 clk_in = ~clk_in;
   pfcd_host #(.ADDR_W(19), .POLL_MAX(8)) u_pfcd_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in), .byte_mode_in(byte_mode_in), .req_in(req_in), .op_in(op_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .busy_out(busy), .done_out(done), .timeout_out(tmo), .rdata_out(rdata),
      .chip_sel_n_out(cs_n), .out_gate_n_out(og_n), .wr_strobe_n_out(we_n), .hw_reset_n_out(rst_n),
      .flash_addr_out(fa), .flash_data_out(fdo), .flash_data_oe_out(oe), .flash_data_in(fdi));
   pfcd_flash_model #(.ADDR_W(19), .MAN(MAN), .DEV(DEV)) u_pfcd_flash_model (.cs_n_in(cs_n), .og_n_in(og_n),
      .we_n_in(we_n), .rst_n_in(rst_n), .byte_in(byte_mode_in), .slow_in(slow), .addr_in(fa), .data_in(fdi),
      .data_out(mdo), .kind_out(kind), .loc_out(mloc), .val_out(mval), .nwr_out(nwr));
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task op(input logic [2:0] o, input logic [18:0] a, input logic [15:0] d);
      int i;
      n0 = nwr;
      req_in = 1'b1; op_in = o; addr_in = a; wdata_in = d;
      @(posedge clk_in);
      #2 req_in = 1'b0;
      for (i = 0; i < 3000 && done !== 1'b1; i++)
      begin
         @(posedge clk_in);
         #2;
      end
      dn = nwr - n0;
      chk("done", done, 1'b1);
   endtask : op
   task t_refuse;
      req_in = 1'b1; op_in = 3'h6;
      repeat (3) @(posedge clk_in);
      #2 chk("busy op6", busy, 1'b0);
      clk_en_in = 1'b0; op_in = 3'h0;
      repeat (3) @(posedge clk_in);
      #2 chk("busy frozen", busy, 1'b0);
      req_in = 1'b0; clk_en_in = 1'b1;
      chk("kind", kind, 3'h0);
      @(posedge clk_in);
      #2;
   endtask : t_refuse
   task t_ident;
      op(3'h0, 19'h40123, 16'h0000);
      chk("array", rdata, 16'h0123 ^ 16'h5a5a);
      op(3'h2, 19'h00000, 16'h0000);
      chk("kind ident", kind, 3'h2);
      chk("ident writes", dn, 4'h3);
      op(3'h0, 19'h7fffc, 16'h0000);
      chk("manuf", rdata, MAN);
      op(3'h0, 19'h7fffd, 16'h0000);
      chk("device", rdata, DEV);
      op(3'h1, 19'h12345, 16'h0000);
      chk("kind reset", kind, 3'h1);
      op(3'h0, 19'h7fffd, 16'h0000);
      chk("array back", rdata, 16'hfffd ^ 16'h5a5a);
   endtask : t_ident
   task t_write;
      int b;
      for (b = 0; b < 2; b++)
      begin
         byte_mode_in = b[0];
         op(3'h3, 19'h61234, 16'hbeef);
         chk("kind prog", kind, 3'h3);
         chk("prog loc", mloc, 19'h61234);
         chk("prog writes", dn, 4'h4);
         chk("prog data", mval, 16'hbeef);
         chk("prog tmo", tmo, 1'b0);
         op(3'h4, 19'h00000, 16'h0000);
         chk("kind chip", kind, 3'h4);
         chk("chip writes", dn, 4'h6);
         op(3'h5, 19'h58000, 16'h0000);
         chk("kind sector", kind, 3'h5);
         chk("sector loc", mloc, 19'h58000);
      end
      byte_mode_in = 1'b0;
   endtask : t_write
   task t_slow;
      slow = 1'b1;
      op(3'h4, 19'h00000, 16'h0000);
      chk("timeout", tmo, 1'b1);
      op(3'h1, 19'h00000, 16'h0000);
      chk("kind busy", kind, 3'h4);
   endtask : t_slow
   initial
   begin
      #2 sys_rst_in = 1'b1;
      repeat (12) @(posedge clk_in);
      #2 sys_rst_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #2;
      t_refuse();
      t_ident();
      t_write();
      t_slow();
      summarize();
   end
   initial
   begin
      #(25 * 60000);
      mismatches++;
      summarize();
   end
endmodule : tb_top
`default_nettype wire
